// ---- inc/mcu_pkg.sv ----
`default_nettype none
package mcu_pkg;
	localparam logic [15:0] CMD_RANGED_PLAY = 16'h040D;
	localparam logic [15:0] CMD_RESET       = 16'h8000;
	localparam logic [15:0] CMD_SCAN        = 16'h000A;
	localparam logic [15:0] CMD_BORDER      = 16'h0207;
	localparam logic [15:0] CMD_ERR_LEVEL   = 16'h0119;
	localparam logic [15:0] CMD_MASK        = 16'h0104;
	localparam logic [15:0] CMD_MUTE        = 16'h8118;
	localparam logic [15:0] CMD_PAUSE       = 16'h000E;
	localparam logic [15:0] CMD_STEP        = 16'h000B;
	localparam logic [15:0] CMD_SLOW        = 16'h0109;
	localparam logic [7:0]  SECTOR_MODE     = 8'h02;
	localparam int EV_STREAM_ERR = 0;
	localparam int EV_NEW_PIC    = 1;
	localparam int EV_SEQ_HDR    = 3;
	localparam int EV_RANGE      = 7;
	localparam int EV_UNDERFLOW  = 8;
	localparam int EV_SLOW_REQ   = 10;
	localparam int EV_USER_DATA  = 12;
	localparam int EV_PAUSE_END  = 13;
	localparam int EV_DUMP_END   = 14;
	localparam int EV_SUBMODE    = 15;
	localparam logic [15:0] EV_LEGAL_MASK = 16'hF58B;
	localparam logic [15:0] ENABLE_RESET  = 16'h0000;
	localparam logic [7:0]  BORDER_Y_RST  = 8'h10;
	localparam logic [7:0]  BORDER_C_RST  = 8'h80;
	localparam int SOFT_MUTE_MS     = 20;
	localparam int CLK_KHZ          = 20000;
	localparam int SOFT_MUTE_CYCLES = SOFT_MUTE_MS * CLK_KHZ;
	localparam logic [1:0] ATTEN_0DB  = 2'h0;
	localparam logic [1:0] ATTEN_12DB = 2'h1;
	localparam logic [1:0] ATTEN_MUTE = 2'h2;
	typedef enum logic [1:0] {PROC_IDLE, PROC_BUSY, PROC_DONE} proc_state_e;
	typedef struct packed {
		logic [7:0] minutes;
		logic [7:0] seconds;
		logic [7:0] frame;
	} msf_s;
	typedef struct packed {
		logic [15:0] opcode;
		logic [15:0] arg0;
		logic [15:0] arg1;
		logic [15:0] arg2;
		logic [15:0] arg3;
	} command_s;
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} colour_s;
endpackage
`default_nettype wire

// ---- logic/msf_compare.sv ----
`timescale 1ns/1ns
`default_nettype none
module msf_compare (
	input  wire mcu_pkg::msf_s addr,
	input  wire mcu_pkg::msf_s start,
	input  wire mcu_pkg::msf_s stop,
	output logic               in_range,
	output logic               at_or_past_stop,
	output logic               before_start
);
	// packed bcd orders like binary, so one wide compare keeps field order
	always_comb begin
		before_start    = addr < start;
		at_or_past_stop = addr >= stop;
		in_range        = !before_start && !at_or_past_stop;
	end
endmodule // msf_compare
`default_nettype wire

// ---- logic/macro_command_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
module macro_command_unit #(
	parameter int SOFT_MUTE_LEN = mcu_pkg::SOFT_MUTE_CYCLES
) (
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	input  wire logic                   cmd_valid,
	input  wire mcu_pkg::command_s      cmd,
	input  wire logic                   host_port_enable_pin,
	input  wire logic                   scan_select_pin,
	input  wire logic [1:0]             host_data_low_pins,
	input  wire logic                   sector_valid,
	input  wire mcu_pkg::msf_s          sector_addr,
	input  wire logic                   intra_pic_found,
	input  wire logic                   pic_has_user_data,
	input  wire logic                   pic_decoded,
	input  wire logic                   pic_corrupt,
	input  wire logic                   audio_unit_found,
	input  wire logic                   audio_sector_found,
	input  wire logic                   rate_buffer_empty,
	input  wire logic                   vblank,
	input  wire logic [15:0]            raw_events,
	input  wire logic                   last_sector_stored,
	output logic                        play_active,
	output logic                        video_decode_en,
	output logic                        audio_decode_en,
	output logic                        paused,
	output logic                        flush_bitstream,
	output logic                        discard_buffers,
	output logic                        user_data_store,
	output logic                        hold_still_picture,
	output logic                        conceal_errors,
	output logic                        abort_display,
	output logic                        border_fill,
	output mcu_pkg::colour_s            border_colour,
	output mcu_pkg::proc_state_e        proc_state,
	output logic [15:0]                 event_enable_word,
	output logic [15:0]                 int_status_word,
	output logic                        int_pin,
	output logic [1:0]                  audio_atten,
	output mcu_pkg::msf_s               resume_addr
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [4:0] pin_meta_r;
	logic [4:0] pin_sync_r;
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pin_meta_r <= 5'h00;
			pin_sync_r <= 5'h00;
		end else begin
			pin_meta_r <= {host_port_enable_pin, scan_select_pin, host_data_low_pins,
				1'b0};
			pin_sync_r <= pin_meta_r;
		end
	end
	logic       host_en;
	logic       scan_pin;
	logic [1:0] mute_pins;
	assign host_en   = pin_sync_r[4];
	assign scan_pin  = pin_sync_r[3];
	assign mute_pins = pin_sync_r[2:1];

	logic scan_pin_d_r;
	always_ff @(posedge core_clk) begin
		if (!rstn) scan_pin_d_r <= 1'b0;
		else scan_pin_d_r <= scan_pin;
	end

	// ************************************************************
	// command decode
	// ************************************************************
	logic take;
	assign take = cmd_valid && host_en;
	logic is_reset;
	logic is_ranged;
	logic is_scan;
	logic is_playtype;
	assign is_reset  = take && cmd.opcode == mcu_pkg::CMD_RESET;
	assign is_ranged = take && cmd.opcode == mcu_pkg::CMD_RANGED_PLAY;
	// a scan pin edge stands in for the scan command with the port off
	assign is_scan   = (take && cmd.opcode == mcu_pkg::CMD_SCAN)
		|| (!host_en && scan_pin && !scan_pin_d_r);
	assign is_playtype = is_ranged || is_scan || (take && (cmd.opcode == mcu_pkg::CMD_PAUSE
		|| cmd.opcode == mcu_pkg::CMD_STEP || cmd.opcode == mcu_pkg::CMD_SLOW));

	logic zero_args;
	assign zero_args = {cmd.arg0, cmd.arg1, cmd.arg2, cmd.arg3} == 64'h0;

	// ************************************************************
	// ranged play and scan sequencer
	// ************************************************************
	typedef enum logic [2:0] {
		SQ_IDLE, SQ_SEEK, SQ_PLAY, SQ_DRAIN, SQ_PAUSED, SQ_SCAN, SQ_SCAN_DONE
	} seq_e;
	seq_e          seq_r;
	mcu_pkg::msf_s start_r;
	mcu_pkg::msf_s stop_r;
	logic          was_paused_r;
	logic          video_go_r;
	logic          audio_go_r;
	logic          pause_like_r;

	logic in_range;
	logic past_stop;
	logic before_start;
	msf_compare u_cmp (
		.addr            (sector_addr),
		.start           (start_r),
		.stop            (stop_r),
		.in_range        (in_range),
		.at_or_past_stop (past_stop),
		.before_start    (before_start)
	);

	logic range_ev;
	logic scan_ev;
	logic user_ev;
	always_comb begin
		range_ev = 1'b0;
		if (sector_valid && seq_r == SQ_SEEK && past_stop) range_ev = 1'b1;
		if (sector_valid && seq_r == SQ_PLAY && !in_range) range_ev = 1'b1;
	end
	assign scan_ev = seq_r == SQ_SCAN_DONE;
	assign user_ev = seq_r == SQ_SCAN && intra_pic_found && pic_has_user_data;

	always_ff @(posedge core_clk) begin
		if (!rstn || is_reset) begin
			seq_r <= SQ_IDLE;
		end else if (is_ranged && !(zero_args && !was_paused_r)) begin
			seq_r <= SQ_SEEK;
		end else if (is_scan) begin
			seq_r <= SQ_SCAN;
		end else begin
			case (seq_r)
				SQ_SEEK: if (sector_valid) begin
					if (past_stop) seq_r <= SQ_IDLE;
					else if (in_range) seq_r <= SQ_PLAY;
				end
				SQ_PLAY: if (sector_valid && (before_start || past_stop))
					seq_r <= past_stop ? SQ_DRAIN : SQ_IDLE;
				SQ_DRAIN: if (rate_buffer_empty) seq_r <= SQ_PAUSED;
				SQ_SCAN: if (pic_decoded && video_go_r) seq_r <= SQ_SCAN_DONE;
				SQ_SCAN_DONE: seq_r <= SQ_IDLE;
				default: ;
			endcase
		end
	end

	// ranged play bounds and resume point
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			start_r <= '0;
			stop_r  <= '1;
		end else if (is_ranged) begin
			if (zero_args && was_paused_r) begin
				start_r <= resume_addr;
				stop_r  <= '1;
			end else begin
				start_r <= {cmd.arg0, cmd.arg1[15:8]};
				stop_r  <= {cmd.arg2, cmd.arg3[15:8]};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || is_reset) begin
			resume_addr  <= '0;
			was_paused_r <= 1'b0;
		end else begin
			if (sector_valid && (seq_r == SQ_PLAY || seq_r == SQ_SEEK))
				resume_addr <= sector_addr;
			if (seq_r == SQ_PAUSED || (take && cmd.opcode == mcu_pkg::CMD_PAUSE))
				was_paused_r <= 1'b1;
			else if (is_ranged)
				was_paused_r <= 1'b0;
		end
	end

	// video waits for an intra picture; audio for its first unit
	always_ff @(posedge core_clk) begin
		if (!rstn || is_reset || is_playtype) begin
			video_go_r <= 1'b0;
			audio_go_r <= 1'b0;
		end else begin
			if ((seq_r == SQ_PLAY || seq_r == SQ_SCAN) && intra_pic_found)
				video_go_r <= 1'b1;
			if (seq_r == SQ_PLAY && audio_unit_found)
				audio_go_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || is_reset) pause_like_r <= 1'b0;
		else if (take && (cmd.opcode == mcu_pkg::CMD_PAUSE
			|| cmd.opcode == mcu_pkg::CMD_STEP || cmd.opcode == mcu_pkg::CMD_SLOW))
			pause_like_r <= 1'b1;
		else if (is_playtype || last_sector_stored) pause_like_r <= 1'b0;
	end

	// ************************************************************
	// data path outputs
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			play_active        <= 1'b0;
			video_decode_en    <= 1'b0;
			audio_decode_en    <= 1'b0;
			paused             <= 1'b0;
			flush_bitstream    <= 1'b0;
			discard_buffers    <= 1'b0;
			user_data_store    <= 1'b0;
			hold_still_picture <= 1'b0;
			abort_display      <= 1'b0;
		end else begin
			play_active     <= seq_r == SQ_PLAY || seq_r == SQ_DRAIN;
			video_decode_en <= (seq_r == SQ_PLAY && video_go_r)
				|| seq_r == SQ_DRAIN || seq_r == SQ_SCAN;
			audio_decode_en <= (seq_r == SQ_PLAY && audio_go_r)
				|| (seq_r == SQ_SCAN && audio_sector_found
				&& audio_atten != mcu_pkg::ATTEN_MUTE);
			paused          <= seq_r == SQ_PAUSED;
			flush_bitstream <= scan_ev || is_reset;
			discard_buffers <= is_reset;
			user_data_store <= user_ev;
			if (is_reset || (is_playtype && !is_scan)) hold_still_picture <= 1'b0;
			else if (scan_ev) hold_still_picture <= 1'b1;
			abort_display   <= pic_corrupt && !conceal_errors;
		end
	end

	// ************************************************************
	// processing state: reset command sets done, any other taken command with opcode bit 15 clear sets busy
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) proc_state <= mcu_pkg::PROC_IDLE;
		else if (is_reset) proc_state <= mcu_pkg::PROC_DONE;
		else if (take && !cmd.opcode[15])
			proc_state <= mcu_pkg::PROC_BUSY;
	end

	// ************************************************************
	// settings: border, error level, mask
	// ************************************************************
	mcu_pkg::colour_s border_pend_r;
	logic             border_new_r;
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			border_pend_r  <= {mcu_pkg::BORDER_Y_RST, mcu_pkg::BORDER_C_RST,
				mcu_pkg::BORDER_C_RST};
			border_new_r   <= 1'b0;
			border_colour  <= {mcu_pkg::BORDER_Y_RST, mcu_pkg::BORDER_C_RST,
				mcu_pkg::BORDER_C_RST};
			border_fill    <= 1'b0;
		end else begin
			if (take && cmd.opcode == mcu_pkg::CMD_BORDER) begin
				border_pend_r <= {cmd.arg1[15:8], cmd.arg1[7:0], cmd.arg0[7:0]};
				border_new_r  <= 1'b1;
			end else if (vblank) begin
				border_new_r <= 1'b0;
			end
			if (vblank && border_new_r) border_colour <= border_pend_r;
			border_fill <= is_reset;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) conceal_errors <= 1'b0;
		else if (take && cmd.opcode == mcu_pkg::CMD_ERR_LEVEL)
			conceal_errors <= cmd.arg0[0];
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) event_enable_word <= mcu_pkg::ENABLE_RESET;
		else if (take && cmd.opcode == mcu_pkg::CMD_MASK)
			event_enable_word <= cmd.arg0 & mcu_pkg::EV_LEGAL_MASK;
	end

	// ************************************************************
	// event collection
	// ************************************************************
	logic [15:0] events;
	always_comb begin
		events = raw_events & mcu_pkg::EV_LEGAL_MASK;
		events[mcu_pkg::EV_RANGE]      = range_ev;
		events[mcu_pkg::EV_USER_DATA]  = user_ev;
		// pause end only counts for pause, step and slow motion
		events[mcu_pkg::EV_PAUSE_END]  = pause_like_r && last_sector_stored;
	end
	logic [15:0] fired;
	assign fired = events & event_enable_word;

	// status word is cleared by reset command; events that coincide still land
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			int_status_word <= 16'h0000;
			int_pin         <= 1'b0;
		end else begin
			int_status_word <= (is_reset ? 16'h0000 : int_status_word) | fired;
			if (fired != 16'h0000 || (!host_en && scan_ev)) int_pin <= 1'b1;
			else if (is_reset || is_playtype) int_pin <= 1'b0;
		end
	end

	// ************************************************************
	// audio attenuation with soft mute ramp
	// ************************************************************
	logic [1:0]  mute_sel_r;
	logic [23:0] ramp_r;
	always_ff @(posedge core_clk) begin
		if (!rstn) mute_sel_r <= 2'h0;
		else if (!host_en) mute_sel_r <= mute_pins;
		else if (take && cmd.opcode == mcu_pkg::CMD_MUTE)
			mute_sel_r <= cmd.arg0[1:0];
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ramp_r      <= 24'h000000;
			audio_atten <= mcu_pkg::ATTEN_0DB;
		end else begin
			case (mute_sel_r)
				2'h0: begin
					ramp_r      <= 24'h000000;
					audio_atten <= mcu_pkg::ATTEN_0DB;
				end
				2'h2: begin
					// full mute only once the 20 ms ramp has run out
					if (ramp_r < 24'(SOFT_MUTE_LEN)) ramp_r <= ramp_r + 24'h000001;
					else audio_atten <= mcu_pkg::ATTEN_MUTE;
				end
				default: begin
					ramp_r      <= 24'h000000;
					audio_atten <= mcu_pkg::ATTEN_12DB;
				end
			endcase
		end
	end

endmodule // macro_command_unit
`default_nettype wire

// ---- verif/mcu_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// checker on the command unit ports
// ****************************************
module mcu_chk #(
	parameter int SOFT_MUTE_LEN = 8
) (
	input wire logic                 core_clk,
	input wire logic                 rstn,
	input wire logic                 cmd_valid,
	input wire mcu_pkg::command_s    cmd,
	input wire logic                 host_port_enable_pin,
	input wire logic                 vblank,
	input wire logic [15:0]          raw_events,
	input wire logic                 discard_buffers,
	input wire logic                 border_fill,
	input wire logic                 conceal_errors,
	input wire mcu_pkg::colour_s     border_colour,
	input wire mcu_pkg::proc_state_e proc_state,
	input wire logic [15:0]          event_enable_word,
	input wire logic [15:0]          int_status_word,
	input wire logic                 int_pin,
	input wire logic [1:0]           audio_atten
);
	// conservative view of the synced enable: on only after four high samples
	logic [3:0] hs_r;
	always_ff @(posedge core_clk) hs_r <= rstn ? {hs_r[2:0], host_port_enable_pin} : 4'h0;
	wire logic host_on = &hs_r;
	wire logic take = host_on && cmd_valid;
	// cycles since a soft mute request, until full mute shows; a counter, as the ramp is long
	int mute_wait;
	always_ff @(posedge core_clk) begin
		if (!rstn || !host_on || audio_atten == mcu_pkg::ATTEN_MUTE) mute_wait <= 0;
		else if (take && cmd.opcode == mcu_pkg::CMD_MUTE)
			mute_wait <= (cmd.arg0[1:0] == 2'h2) ? 1 : 0;
		else if (mute_wait != 0) mute_wait <= mute_wait + 1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_rst; $rose(rstn) |-> proc_state == mcu_pkg::PROC_IDLE && !int_pin
		&& audio_atten == mcu_pkg::ATTEN_0DB && border_colour == 24'h108080; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_done; $rose(proc_state == mcu_pkg::PROC_DONE)
		|-> $past(cmd_valid && cmd.opcode == mcu_pkg::CMD_RESET); endproperty
	a_done: assert property (p_done) else $error("done without reset");
	property p_keep; take && cmd.opcode == mcu_pkg::CMD_MUTE |=> $stable(proc_state); endproperty
	a_keep: assert property (p_keep) else $error("mute moved state");
	property p_disc; take && cmd.opcode == mcu_pkg::CMD_RESET |=> discard_buffers && border_fill;
	endproperty
	a_disc: assert property (p_disc) else $error("reset did not discard");
	property p_mute; take && cmd.opcode == mcu_pkg::CMD_MUTE && cmd.arg0[1:0] != 2'h2
		|=> ##1 audio_atten == ($past(cmd.arg0[0], 2) ? mcu_pkg::ATTEN_12DB : mcu_pkg::ATTEN_0DB);
	endproperty
	a_mute: assert property (p_mute) else $error("attenuation wrong");
	property p_soft; mute_wait <= SOFT_MUTE_LEN + 4; endproperty
	a_soft: assert property (p_soft) else $error("soft mute late");
	property p_bord; !$stable(border_colour) |-> $past(vblank) || $past(vblank, 2); endproperty
	a_bord: assert property (p_bord) else $error("border changed off blanking");
	property p_err; take && cmd.opcode == mcu_pkg::CMD_ERR_LEVEL
		|=> conceal_errors == $past(cmd.arg0[0]); endproperty
	a_err: assert property (p_err) else $error("error level wrong");
	property p_mask; take && cmd.opcode == mcu_pkg::CMD_MASK
		|=> event_enable_word == ($past(cmd.arg0) & mcu_pkg::EV_LEGAL_MASK); endproperty
	a_mask: assert property (p_mask) else $error("enable word wrong");
	property p_ev; raw_events[0] && event_enable_word[0] |=> int_status_word[0] && int_pin;
	endproperty
	a_ev: assert property (p_ev) else $error("enabled event lost");
	property p_off; raw_events[1] && !event_enable_word[1] && !int_status_word[1]
		|=> !int_status_word[1]; endproperty
	a_off: assert property (p_off) else $error("masked event seen");
endmodule // mcu_chk
bind macro_command_unit mcu_chk #(.SOFT_MUTE_LEN(SOFT_MUTE_LEN)) u_chk (
	.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
	.host_port_enable_pin(host_port_enable_pin), .vblank(vblank),
	.raw_events(raw_events), .discard_buffers(discard_buffers),
	.border_fill(border_fill), .conceal_errors(conceal_errors),
	.border_colour(border_colour), .proc_state(proc_state),
	.event_enable_word(event_enable_word), .int_status_word(int_status_word),
	.int_pin(int_pin), .audio_atten(audio_atten)
);
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// host side command issuer
// ****************************************
module host_model (
	input  wire logic         core_clk,
	output logic              cmd_valid,
	output mcu_pkg::command_s cmd
);
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end
	// the command word is scrambled once released, so stale values never look valid
	task send(input logic [15:0] op, a0, a1, a2, a3);
		@(posedge core_clk);
		#2;
		cmd = {op, a0, a1, a2, a3};
		cmd_valid = 1'b1;
		@(posedge core_clk);
		#2;
		cmd_valid = 1'b0;
		cmd = ~cmd;
	endtask
	task ranged(input mcu_pkg::msf_s st, sp);
		send(mcu_pkg::CMD_RANGED_PLAY, {st.minutes, st.seconds}, {st.frame, mcu_pkg::SECTOR_MODE},
			{sp.minutes, sp.seconds}, {sp.frame, mcu_pkg::SECTOR_MODE});
	endtask
endmodule // host_model
`default_nettype wire

// ---- verif/decoder_macro_command_unit_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// command unit bench
// ****************************************
module decoder_macro_command_unit_tb;
	logic core_clk, rstn, cmd_valid, host_port_enable_pin, scan_select_pin, sector_valid;
	logic intra_pic_found, pic_has_user_data, pic_decoded, pic_corrupt, audio_unit_found;
	logic audio_sector_found, rate_buffer_empty, vblank, last_sector_stored, play_active;
	logic video_decode_en, audio_decode_en, paused, flush_bitstream, discard_buffers;
	logic user_data_store, hold_still_picture, conceal_errors, abort_display, border_fill, int_pin;
	logic [1:0] host_data_low_pins, audio_atten;
	logic [15:0] raw_events, event_enable_word, int_status_word;
	logic [2:0] seen;
	mcu_pkg::command_s cmd;
	mcu_pkg::msf_s sector_addr, resume_addr;
	mcu_pkg::colour_s border_colour;
	mcu_pkg::proc_state_e proc_state;
	int fail_count = 0, compares = 0, cycles = 0, i, clr_req = 0, clr_ack = 0;
	host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd));
	macro_command_unit #(.SOFT_MUTE_LEN(8)) dut (
		.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
		.host_port_enable_pin(host_port_enable_pin),
		.scan_select_pin(scan_select_pin),
		.host_data_low_pins(host_data_low_pins), .sector_valid(sector_valid),
		.sector_addr(sector_addr), .intra_pic_found(intra_pic_found),
		.pic_has_user_data(pic_has_user_data), .pic_decoded(pic_decoded),
		.pic_corrupt(pic_corrupt), .audio_unit_found(audio_unit_found),
		.audio_sector_found(audio_sector_found),
		.rate_buffer_empty(rate_buffer_empty), .vblank(vblank),
		.raw_events(raw_events), .last_sector_stored(last_sector_stored),
		.play_active(play_active), .video_decode_en(video_decode_en),
		.audio_decode_en(audio_decode_en), .paused(paused),
		.flush_bitstream(flush_bitstream), .discard_buffers(discard_buffers),
		.user_data_store(user_data_store),
		.hold_still_picture(hold_still_picture),
		.conceal_errors(conceal_errors), .abort_display(abort_display),
		.border_fill(border_fill), .border_colour(border_colour),
		.proc_state(proc_state), .event_enable_word(event_enable_word),
		.int_status_word(int_status_word), .int_pin(int_pin),
		.audio_atten(audio_atten), .resume_addr(resume_addr)
	);
	always #25 core_clk = ~core_clk;
	// pulses are caught here so a check a few cycles later still sees them
	always @(posedge core_clk) begin
		// the scenario asks for a clear by bumping clr_req; only this block writes seen
		seen <= ((!rstn || clr_req != clr_ack) ? 3'h0 : seen)
			| {user_data_store, discard_buffers, flush_bitstream};
		clr_ack <= clr_req;
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			results();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task sec(input logic [23:0] a);
		sector_valid = 1'b1;
		sector_addr = a;
		cyc(1);
		sector_valid = 1'b0;
		sector_addr = ~a;
	endtask
	task rst_mask(input logic [15:0] m);
		host.send(mcu_pkg::CMD_RESET, 0, 0, 0, 0);
		host.send(mcu_pkg::CMD_MASK, m, 0, 0, 0);
	endtask
	task results;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{core_clk, rstn, scan_select_pin, sector_valid, intra_pic_found, pic_has_user_data} = '0;
		{pic_decoded, pic_corrupt, audio_unit_found, audio_sector_found, vblank} = '0;
		{rate_buffer_empty, last_sector_stored, host_data_low_pins, raw_events} = '0;
		host_port_enable_pin = 1'b1;
		sector_addr = '0;
		cyc(5);
		rstn = 1'b1;
		cyc(4);
		chk(border_colour, 24'h108080);
		chk(proc_state, mcu_pkg::PROC_IDLE);
		host.send(mcu_pkg::CMD_MASK, 16'h1081, 0, 0, 0);
		cyc(1);
		chk(event_enable_word, 16'h1081);
		raw_events = 16'h0003;
		cyc(1);
		raw_events = '0;
		cyc(1);
		chk(int_status_word[1:0], 2'b01);
		chk(int_pin, 1);
		for (i = 0; i < 4; i++) begin
			host.send(mcu_pkg::CMD_MUTE, 16'(i), 0, 0, 0);
			cyc(12);
			chk(audio_atten, (i == 2) ? 2 : (i & 1));
		end
		chk(proc_state, mcu_pkg::PROC_BUSY);
		for (i = 0; i < 2; i++) begin
			host.send(mcu_pkg::CMD_ERR_LEVEL, 16'(i), 0, 0, 0);
			cyc(1);
			chk(conceal_errors, i);
			pulse(pic_corrupt);
			chk(abort_display, i == 0);
		end
		host.send(mcu_pkg::CMD_BORDER, 16'h00AB, 16'hC3D4, 0, 0);
		cyc(3);
		chk(border_colour, 24'h108080);
		pulse(vblank);
		cyc(2);
		chk(border_colour, 24'hC3D4AB);
		clr_req++;
		host.send(mcu_pkg::CMD_RESET, 0, 0, 0, 0);
		cyc(1);
		chk(proc_state, mcu_pkg::PROC_DONE);
		chk({seen[1], int_pin, int_status_word}, 18'h20000);
		host.send(mcu_pkg::CMD_MASK, 16'h2080, 0, 0, 0);
		host.ranged(24'h000200, 24'h000500);
		cyc(2);
		sec(24'h000600);
		cyc(2);
		chk({play_active, int_pin, int_status_word[7]}, 3'b011);
		rst_mask(16'h2080);
		host.ranged(24'h010000, 24'h020000);
		cyc(2);
		sec(24'h005974);
		cyc(2);
		chk(int_status_word[7], 0);
		sec(24'h013000);
		cyc(3);
		chk({play_active, video_decode_en}, 2'b10);
		pulse(intra_pic_found);
		cyc(3);
		chk(video_decode_en, 1);
		pulse(audio_unit_found);
		cyc(1);
		chk(audio_decode_en, 1);
		raw_events[13] = 1'b1;
		cyc(1);
		raw_events[13] = 1'b0;
		cyc(2);
		chk(int_status_word[13], 0);
		sec(24'h020000);
		cyc(3);
		chk(paused, 0);
		rate_buffer_empty = 1'b1;
		cyc(4);
		chk(paused, 1);
		rate_buffer_empty = 1'b0;
		chk(resume_addr, 24'h020000);
		host.send(mcu_pkg::CMD_PAUSE, 0, 0, 0, 0);
		pulse(last_sector_stored);
		cyc(1);
		chk(int_status_word[13], 1);
		host.send(mcu_pkg::CMD_RANGED_PLAY, 0, 0, 0, 0);
		cyc(2);
		sec(24'h020001);
		cyc(2);
		chk(play_active, 1);
		rst_mask(16'h0080);
		host.ranged(24'h010000, 24'h020000);
		cyc(2);
		sec(24'h013000);
		cyc(2);
		sec(24'h005000);
		cyc(2);
		chk({int_pin, int_status_word[7]}, 2'b11);
		rst_mask(16'h1000);
		clr_req++;
		host.send(mcu_pkg::CMD_SCAN, 0, 0, 0, 0);
		cyc(2);
		pulse(audio_sector_found);
		chk(audio_decode_en, 1);
		pic_has_user_data = 1'b1;
		pulse(intra_pic_found);
		pic_has_user_data = 1'b0;
		pulse(pic_decoded);
		cyc(3);
		chk({seen[2], int_status_word[12]}, 2'b11);
		chk(seen[0], 1);
		chk(hold_still_picture, 1);
		host.send(mcu_pkg::CMD_PAUSE, 0, 0, 0, 0);
		cyc(2);
		chk(hold_still_picture, 0);
		host.send(mcu_pkg::CMD_RESET, 0, 0, 0, 0);
		host_port_enable_pin = 1'b0;
		cyc(4);
		host_data_low_pins = 2'b01;
		cyc(5);
		chk(audio_atten, 1);
		scan_select_pin = 1'b1;
		cyc(5);
		chk(int_pin, 0);
		pulse(intra_pic_found);
		pulse(pic_decoded);
		cyc(4);
		chk(int_pin, 1);
		results();
	end
endmodule // decoder_macro_command_unit_tb
`default_nettype wire
